// ==== logic/asp_uart.sv ====
// Serial port with baud timer, receive buffer and Wishbone registers
`timescale 1ns/10ps
module asp_uart (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  // Register bus
  input  wire asp_pkg::asp_wb_req_t wb_req,
  output asp_pkg::asp_wb_rsp_t      wb_rsp,
  // Serial pins
  input  wire logic               serial_in_pin,
  output logic                    serial_out_pin,
  // Timer clock sources
  input  wire logic               ext_osc_in,
  input  wire logic               baud_timer_ext_input,
  // Interrupt request
  output logic                    uart_irq
);

  // All state of the block
  typedef struct packed {
    asp_pkg::asp_wb_rsp_t rsp;
    logic                 mode;
    logic                 mce;
    logic                 ren;
    logic                 tb8;
    logic                 rb8;
    logic                 ti;
    logic                 ri;
    logic [7:0]           rbuf;
    logic [7:0]           reload;
    logic                 run;
    logic [2:0]           csel;
    logic                 irq_en;
    logic                 irq;
    logic [7:0]           tcnt;
    logic                 thalf;
    logic [7:0]           rcnt;
    logic                 rhalf;
    logic [5:0]           pre;
    logic [2:0]           odiv;
    logic [2:0]           rx_s;
    logic [2:0]           osc_s;
    logic [2:0]           ext_s;
    asp_pkg::asp_tx_st_t  tx_st;
    logic [8:0]           tx_sh;
    logic [3:0]           tx_cnt;
    logic                 txd;
    asp_pkg::asp_rx_st_t  rx_st;
    logic [8:0]           rx_sh;
    logic [3:0]           rx_cnt;
  } asp_state_t;

  asp_state_t q;
  asp_state_t d;

  // Overflow of an 8-bit up counter on a tick
  function automatic logic asp_ovf(
    input logic [7:0] cnt,
    input logic       tick
  );
    asp_ovf = tick && (cnt == asp_pkg::TMR_TOP);
  endfunction : asp_ovf

  // Next count of an auto-reload timer
  function automatic logic [7:0] asp_next(
    input logic [7:0] cnt,
    input logic       tick,
    input logic [7:0] rld
  );
    if (!tick) begin
      asp_next = cnt;
    end else if (cnt == asp_pkg::TMR_TOP) begin
      asp_next = rld;
    end else begin
      asp_next = cnt + 8'h01;
    end
  endfunction : asp_next

  // Decoded bus access
  logic       acc;
  logic       wr;
  logic       rd_unused;
  logic [7:0] wdat;
  logic       wr_ctrl;
  logic       wr_data;
  logic       wr_cfg;
  logic       wr_cnt;
  logic       rd_ok;
  logic [31:0] rdat;

  // Timer ticks and events
  logic       tick;
  logic       osc_rise;
  logic       ext_rise;
  logic       tovf;
  logic       rovf;
  logic       tx_bit;
  logic       rx_smp;
  logic       start_det;
  logic       rx_in;
  logic       ninth;
  logic       load_ok;
  logic [3:0] nbits;
  logic       set_ti;
  logic       set_ri;

  always_comb begin
    d = q;
    rdat = 32'h0000_0000;
    rd_ok = 1'b0;
    rd_unused = 1'b0;
    set_ti = 1'b0;
    set_ri = 1'b0;
    ninth = 1'b0;
    load_ok = 1'b0;

    // Bus decode; one access per request, ack one cycle later
    acc = wb_req.cyc && wb_req.stb && !q.rsp.ack;
    wr = acc && wb_req.we && wb_req.sel[0];
    rd_unused = acc && !wb_req.we;
    wdat = wb_req.dat[7:0];
    wr_ctrl = wr && (wb_req.adr == asp_pkg::OFS_CTRL);
    wr_data = wr && (wb_req.adr == asp_pkg::OFS_DATA);
    wr_cfg = acc && wb_req.we && (wb_req.adr == asp_pkg::OFS_TIMCFG);
    wr_cnt = wr && (wb_req.adr == asp_pkg::OFS_TIMCNT);
    nbits = q.mode ? asp_pkg::BITS_9 : asp_pkg::BITS_8;

    // Pin synchronisers and edge history
    d.rx_s = {q.rx_s[1:0], serial_in_pin};
    d.osc_s = {q.osc_s[1:0], ext_osc_in};
    d.ext_s = {q.ext_s[1:0], baud_timer_ext_input};
    rx_in = q.rx_s[1];
    osc_rise = q.osc_s[1] && !q.osc_s[2];
    ext_rise = q.ext_s[1] && !q.ext_s[2];

    // Prescaler shared by the divided core clock sources
    d.pre = (q.pre == asp_pkg::PRE_LAST) ? 6'h00 : q.pre + 6'h01;
    if (osc_rise) begin
      d.odiv = q.odiv + 3'h1;
    end

    // Timer clock select
    case (q.csel)
      asp_pkg::CS_CORE: tick = 1'b1;
      asp_pkg::CS_DIV4: tick = (q.pre[1:0] == 2'h3);
      asp_pkg::CS_D12: tick = (q.pre == 6'h0b) || (q.pre == 6'h17) ||
                              (q.pre == 6'h23) || (q.pre == 6'h2f);
      asp_pkg::CS_D48: tick = (q.pre == asp_pkg::PRE_LAST);
      asp_pkg::CS_OSC8: tick = osc_rise && (q.odiv == asp_pkg::OSC_LAST);
      asp_pkg::CS_EXT: tick = ext_rise;
      default: tick = 1'b0;
    endcase
    tick = tick && q.run;

    // Transmit timer: auto-reload on the count byte
    tovf = asp_ovf(q.tcnt, tick);
    d.tcnt = asp_next(q.tcnt, tick, q.reload);
    if (tovf) begin
      d.thalf = !q.thalf;
    end
    tx_bit = tovf && q.thalf; // Every second overflow

    // Hidden receive timer on the same reload byte
    rovf = asp_ovf(q.rcnt, tick);
    d.rcnt = asp_next(q.rcnt, tick, q.reload);
    if (rovf) begin
      d.rhalf = !q.rhalf;
    end
    rx_smp = rovf && !q.rhalf; // First of each pair is mid-bit

    // Start edge seen while enabled and idle
    start_det = q.rx_st[0] && q.ren && q.run &&
                q.rx_s[2] && !rx_in; // Idle high, start low
    if (start_det) begin
      d.rcnt = q.reload; // Forced reload realigns bit phase
      d.rhalf = 1'b0;
    end

    // Transmitter
    case (q.tx_st)
      asp_pkg::TX_IDLE: begin
        d.txd = 1'b1; // Line idles high
        if (wr_data) begin
          d.txd = 1'b0; // Start bit at once
          d.tx_sh = {q.tb8, wdat}; // Ninth bit from control
          d.tx_cnt = nbits; // Ten or eleven bit frame
          d.thalf = 1'b0;
          d.tx_st = asp_pkg::TX_DATA;
        end
      end
      asp_pkg::TX_DATA: begin
        if (tx_bit) begin
          if (q.tx_cnt == 4'h0) begin
            d.txd = 1'b1; // Stop bit high
            set_ti = 1'b1; // Done at start of stop
            d.tx_st = asp_pkg::TX_STOP;
          end else begin
            d.txd = q.tx_sh[0]; // LSB first
            d.tx_sh = {1'b0, q.tx_sh[8:1]};
            d.tx_cnt = q.tx_cnt - 4'h1;
          end
        end
      end
      asp_pkg::TX_STOP: begin
        if (tx_bit) begin
          d.tx_st = asp_pkg::TX_IDLE; // Full stop bit elapsed
        end
      end
      default: begin
        d.txd = 1'b1;
        d.tx_st = asp_pkg::TX_IDLE;
      end
    endcase

    // Receiver into its own shifter
    case (q.rx_st)
      asp_pkg::RX_IDLE: begin
        if (start_det) begin
          d.rx_cnt = 4'h0;
          d.rx_st = asp_pkg::RX_START;
        end
      end
      asp_pkg::RX_START: begin
        if (rx_smp) begin
          if (rx_in) begin
            d.rx_st = asp_pkg::RX_IDLE; // Glitch, not a start
          end else begin
            d.rx_st = asp_pkg::RX_DATA;
          end
        end
      end
      asp_pkg::RX_DATA: begin
        if (rx_smp) begin
          d.rx_sh = {rx_in, q.rx_sh[8:1]};
          d.rx_cnt = q.rx_cnt + 4'h1;
          if (q.rx_cnt == nbits - 4'h1) begin
            d.rx_st = asp_pkg::RX_STOP;
          end
        end
      end
      asp_pkg::RX_STOP: begin
        if (rx_smp) begin
          // 9-bit keeps ninth data bit, 8-bit the stop bit
          ninth = q.mode ? q.rx_sh[8] : rx_in;
          // Filter and overrun
          load_ok = !q.ri && (!q.mce || ninth);
          if (load_ok) begin
            d.rbuf = q.mode ? q.rx_sh[7:0] : q.rx_sh[8:1];
            d.rb8 = ninth;
            set_ri = 1'b1;
          end
          d.rx_st = asp_pkg::RX_IDLE;
        end
      end
      default: begin
        d.rx_st = asp_pkg::RX_IDLE;
      end
    endcase
    if (!q.run) begin
      d.rx_st = asp_pkg::RX_IDLE;
    end

    // Control register write; hardware set beats software clear
    if (wr_ctrl) begin
      d.mode = wdat[asp_pkg::B_MODE]; // Frame width select
      d.mce = wdat[asp_pkg::B_MCE];
      d.ren = wdat[asp_pkg::B_REN];
      d.tb8 = wdat[asp_pkg::B_TB8];
      d.rb8 = wdat[asp_pkg::B_RB8];
      d.ti = wdat[asp_pkg::B_TI];
      d.ri = wdat[asp_pkg::B_RI];
      if (load_ok) begin
        d.rb8 = ninth;
      end
    end
    if (set_ti) begin
      d.ti = 1'b1;
    end
    if (set_ri) begin
      d.ri = 1'b1;
    end

    // Timer config and count writes by byte lane
    if (wr_cfg && wb_req.sel[0]) begin
      d.reload = wdat;
    end
    if (wr_cfg && wb_req.sel[1]) begin
      d.run = wb_req.dat[asp_pkg::B_RUN];
      d.csel = wb_req.dat[asp_pkg::B_CSL +: 3];
      d.irq_en = wb_req.dat[asp_pkg::B_IRQE];
    end
    if (wr_cnt) begin
      d.tcnt = wdat;
    end

    // Interrupt request follows the done flags
    d.irq = q.irq_en && (d.ti || d.ri);

    // Read mux; data address returns receive buffer only
    case (wb_req.adr)
      asp_pkg::OFS_CTRL: begin
        rdat[7:0] = {q.mode, 1'b1, q.mce, q.ren, q.tb8, q.rb8, q.ti, q.ri};
        rd_ok = 1'b1;
      end
      asp_pkg::OFS_DATA: begin
        rdat[7:0] = q.rbuf;
        rd_ok = 1'b1;
      end
      asp_pkg::OFS_TIMCFG: begin
        rdat[7:0] = q.reload;
        rdat[asp_pkg::B_RUN] = q.run;
        rdat[asp_pkg::B_CSL +: 3] = q.csel;
        rdat[asp_pkg::B_IRQE] = q.irq_en;
        rd_ok = 1'b1;
      end
      asp_pkg::OFS_TIMCNT: begin
        rdat[7:0] = q.tcnt;
        rd_ok = 1'b1;
      end
      default: begin
        rdat = 32'h0000_0000; // Unmapped reads zero
        rd_ok = 1'b0;
      end
    endcase

    // Bus answer one cycle after the request
    d.rsp.ack = acc;
    if (rd_unused && rd_ok) begin
      d.rsp.dat = rdat;
    end else if (acc) begin
      d.rsp.dat = 32'h0000_0000;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q.rsp <= '0;
      q.mode <= 1'b0;
      q.mce <= 1'b0;
      q.ren <= 1'b0;
      q.tb8 <= 1'b0;
      q.rb8 <= 1'b0;
      q.ti <= 1'b0;
      q.ri <= 1'b0;
      q.rbuf <= asp_pkg::RST_BYTE;
      q.reload <= asp_pkg::RST_BYTE;
      q.run <= 1'b0;
      q.csel <= asp_pkg::RST_CSL;
      q.irq_en <= 1'b0;
      q.irq <= 1'b0;
      q.tcnt <= asp_pkg::RST_BYTE;
      q.thalf <= 1'b0;
      q.rcnt <= asp_pkg::RST_BYTE;
      q.rhalf <= 1'b0;
      q.pre <= 6'h00;
      q.odiv <= 3'h0;
      q.rx_s <= 3'h7;
      q.osc_s <= 3'h0;
      q.ext_s <= 3'h0;
      q.tx_st <= asp_pkg::TX_IDLE;
      q.tx_sh <= 9'h000;
      q.tx_cnt <= 4'h0;
      q.txd <= 1'b1;
      q.rx_st <= asp_pkg::RX_IDLE;
      q.rx_sh <= 9'h000;
      q.rx_cnt <= 4'h0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state
  assign wb_rsp = q.rsp;
  assign serial_out_pin = q.txd;
  assign uart_irq = q.irq;

endmodule : asp_uart

// ==== logic/asp_pkg.sv ====
// Package with constants, states and carrier types for the serial port
package asp_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DATA   = 8'h04;
  localparam logic [7:0] OFS_TIMCFG = 8'h08;
  localparam logic [7:0] OFS_TIMCNT = 8'h0c;
  // Control register bit positions
  localparam int B_MODE = 7;
  localparam int B_ONE  = 6;
  localparam int B_MCE  = 5;
  localparam int B_REN  = 4;
  localparam int B_TB8  = 3;
  localparam int B_RB8  = 2;
  localparam int B_TI   = 1;
  localparam int B_RI   = 0;
  // Timer config bit positions
  localparam int B_RUN  = 8;
  localparam int B_CSL  = 9;
  localparam int B_IRQE = 12;
  // Clock source codes
  localparam logic [2:0] CS_CORE = 3'h0;
  localparam logic [2:0] CS_DIV4 = 3'h1;
  localparam logic [2:0] CS_D12  = 3'h2;
  localparam logic [2:0] CS_D48  = 3'h3;
  localparam logic [2:0] CS_OSC8 = 3'h4;
  localparam logic [2:0] CS_EXT  = 3'h5;
  // Timing counts
  localparam logic [5:0] PRE_LAST = 6'h2f;
  localparam logic [2:0] OSC_LAST = 3'h7;
  localparam logic [7:0] TMR_TOP  = 8'hff;
  localparam logic [3:0] BITS_8   = 4'h8;
  localparam logic [3:0] BITS_9   = 4'h9;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_CSL  = 3'h0;
  // Transmit and receive states
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_DATA = 3'b010,
    TX_STOP = 3'b100
  } asp_tx_st_t;
  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } asp_rx_st_t;
  // Wishbone carriers
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } asp_wb_req_t;
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } asp_wb_rsp_t;
endpackage : asp_pkg

// ==== testbench/asp_uart_asserts.sv ====
// Port-level checker for the serial port
`timescale 1ns/10ps
module asp_uart_asserts (
  // Clock and reset
  input wire logic                 ref_clk,
  input wire logic                 rst_n,
  // Register bus
  input wire asp_pkg::asp_wb_req_t wb_req,
  input wire asp_pkg::asp_wb_rsp_t wb_rsp,
  // Pins
  input wire logic                 serial_out_pin,
  input wire logic                 uart_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Bus answers: one-cycle ack, fixed latency, quiet data lanes
  ack_one_cycle_a: assert property (wb_rsp.ack |=> !wb_rsp.ack) else $error("ack held");
  ack_latency_a: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack)
    else $error("ack late");
  write_dat_zero_a: assert property (wb_rsp.ack && $past(wb_req.we) |-> wb_rsp.dat == 32'h0)
    else $error("write data");
  unmapped_zero_a: assert property (wb_rsp.ack && $past(wb_req.adr) > 8'h0c |-> wb_rsp.dat == 32'h0)
    else $error("unmapped");
  buf_upper_zero_a: assert property (wb_rsp.ack && $past(wb_req.adr) == 8'h04 |-> wb_rsp.dat[31:8] == 24'h0)
    else $error("upper");
  // Quiet outputs straight after reset
  irq_after_reset_a: assert property ($rose(rst_n) |-> !uart_irq) else $error("irq after reset");
  line_after_reset_a: assert property ($rose(rst_n) |-> serial_out_pin) else $error("line low after reset");
  // No high bit on the line is shorter than two clock cycles
  bit_min_len_a: assert property ($rose(serial_out_pin) |=> serial_out_pin) else $error("short bit");
  // Interrupt only drops after a software write
  irq_fall_sw_a: assert property ($fell(uart_irq) |->
    $past(wb_req.we && wb_req.stb) || $past(wb_req.we && wb_req.stb, 2))
    else $error("irq dropped by itself");
endmodule : asp_uart_asserts

bind asp_uart asp_uart_asserts i_asp_uart_asserts (.ref_clk(ref_clk), .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
  .serial_out_pin(serial_out_pin), .uart_irq(uart_irq));

// ==== testbench/asp_peer.sv ====
// Far-end serial device that sends and receives frames
`timescale 1ns/10ps
module asp_peer (
  // Clock
  input wire logic clk,
  // Serial lines
  input wire logic tx_line,
  output logic     rx_line
);
  int bit_cyc = 32;  // Bit period in clk cycles

  // Line idles high
  initial rx_line = 1'b1;

  // Start bit low, n bits LSB first, then one idle bit high
  task automatic send(input logic [10:0] bits, input int n);
    @(posedge clk);
    rx_line <= 1'b0;
    repeat (bit_cyc) @(posedge clk);
    for (int k = 0; k < n; k++) begin
      rx_line <= bits[k];
      repeat (bit_cyc) @(posedge clk);
    end
    rx_line <= 1'b1;
    repeat (bit_cyc) @(posedge clk);
  endtask : send

  // Find the start, then sample n bits; the start bit may be short, so sample a quarter bit in
  task automatic recv(input int n, output logic [10:0] got);
    got = '0;
    @(posedge clk);
    while (tx_line !== 1'b0) @(posedge clk);
    repeat (bit_cyc / 4) @(posedge clk);
    for (int k = 0; k < n; k++) begin
      repeat (bit_cyc) @(posedge clk);
      got[k] = tx_line;
    end
  endtask : recv
endmodule : asp_peer

// ==== testbench/asp_uart_test.sv ====
// Self-checking bench for the serial port
`timescale 1ns/10ps
module asp_uart_test;
  logic                 ref_clk;
  logic                 rst_n;
  asp_pkg::asp_wb_req_t wb_req;
  asp_pkg::asp_wb_rsp_t wb_rsp;
  logic                 serial_in_pin;
  logic                 serial_out_pin;
  logic                 ext_osc_in;
  logic                 baud_timer_ext_input;
  logic                 uart_irq;
  logic [31:0]          rd;
  logic [10:0]          frm;
  int                   miscompares;
  int                   tests_run;

  // Design and far end
  asp_uart i_asp_uart (.ref_clk(ref_clk), .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .ext_osc_in(ext_osc_in),
    .baud_timer_ext_input(baud_timer_ext_input), .uart_irq(uart_irq));
  asp_peer i_asp_peer (.clk(ref_clk), .tx_line(serial_out_pin), .rx_line(serial_in_pin));

  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One classic Wishbone cycle, held until ack is sampled
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wb_req <= '{1'b1, 1'b1, we, a, 4'h3, d};
    do @(posedge ref_clk); while (wb_rsp.ack !== 1'b1);
    rd = wb_rsp.dat;
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
  endtask : bus

  // Read a register and compare
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rc

  // Reset values and an unmapped place
  task automatic t_regs();
    rc(8'h00, 32'h40);
    rc(8'h04, 32'h00);
    rc(8'h10, 32'h00);
  endtask : t_regs

  // Transmit from each core-clock source
  task automatic t_tx();
    logic [7:0] rld [4];
    int         bc [4];
    rld = '{8'hf0, 8'hfc, 8'hff, 8'hff};
    bc = '{32, 32, 24, 96};
    // Count byte resets to zero; start it at the top so the first tick overflows
    bus(1'b1, 8'h0c, 32'hff);
    rc(8'h0c, 32'hff);
    for (int i = 3; i >= 0; i--) begin
      i_asp_peer.bit_cyc = bc[i];
      bus(1'b1, 8'h08, 32'h1100 | (i << 9) | rld[i]);
      bus(1'b1, 8'h00, 32'h00);
      bus(1'b1, 8'h04, 32'ha5);
      chk({31'h0, serial_out_pin}, 32'h0);
      i_asp_peer.recv(9, frm);
      chk({21'h0, frm}, 32'h1a5);
      rc(8'h00, 32'h42);
      chk({31'h0, uart_irq}, 32'h1);
      rc(8'h04, 32'h00);
      repeat (bc[i]) @(posedge ref_clk);
    end
    rc(8'h00, 32'h42);
    bus(1'b1, 8'h00, 32'h00);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, uart_irq}, 32'h0);
  endtask : t_tx

  // Receive, second byte while first waits, overrun, filter, disable
  task automatic t_rx();
    bus(1'b1, 8'h00, 32'h10);
    i_asp_peer.send(11'h13c, 9);
    rc(8'h00, 32'h55);
    chk({31'h0, uart_irq}, 32'h1);
    fork
      i_asp_peer.send(11'h196, 9);
      begin
        repeat (96) @(posedge ref_clk);
        rc(8'h04, 32'h3c);
        bus(1'b1, 8'h00, 32'h10);
      end
    join
    rc(8'h04, 32'h96);
    i_asp_peer.send(11'h177, 9);
    rc(8'h04, 32'h96);
    bus(1'b1, 8'h00, 32'h30);
    i_asp_peer.send(11'h0c3, 9);
    rc(8'h00, 32'h70);
    bus(1'b1, 8'h00, 32'h00);
    i_asp_peer.send(11'h1aa, 9);
    rc(8'h00, 32'h40);
  endtask : t_rx

  // Nine-bit frames and address filtering
  task automatic t_nine();
    bus(1'b1, 8'h00, 32'h98);
    bus(1'b1, 8'h04, 32'h5a);
    i_asp_peer.recv(10, frm);
    chk({21'h0, frm}, 32'h35a);
    rc(8'h00, 32'hda);
    repeat (32) @(posedge ref_clk);
    bus(1'b1, 8'h00, 32'hb0);
    i_asp_peer.send(11'h211, 10);
    rc(8'h00, 32'hf0);
    i_asp_peer.send(11'h122, 10);
    rc(8'h00, 32'hf5);
    rc(8'h04, 32'h22);
  endtask : t_nine

  // External oscillator and external input as timer clocks
  task automatic t_src();
    for (int s = 4; s <= 5; s++) begin
      bus(1'b1, 8'h08, 32'h0000);
      bus(1'b1, 8'h0c, 32'h00);
      bus(1'b1, 8'h08, 32'h0100 | (s << 9));
      rc(8'h08, 32'h0100 | (s << 9));
      repeat (16) begin
        ext_osc_in <= 1'b1;
        baud_timer_ext_input <= 1'b1;
        repeat (2) @(posedge ref_clk);
        ext_osc_in <= 1'b0;
        baud_timer_ext_input <= 1'b0;
        repeat (2) @(posedge ref_clk);
      end
      repeat (4) @(posedge ref_clk);
      // Sixteen rising edges: two ticks through the divide by eight, sixteen direct
      rc(8'h0c, (s == 4) ? 32'h02 : 32'h10);
    end
  endtask : t_src

  // Verdict and end of run
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // Main sequence
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    wb_req = '0;
    ext_osc_in = 1'b0;
    baud_timer_ext_input = 1'b0;
    miscompares = 0;
    tests_run = 0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    t_tx();
    t_rx();
    t_nine();
    t_src();
    results();
  end

  // Watchdog well past the expected run length
  initial begin
    repeat (60000) @(posedge ref_clk);
    miscompares++;
    results();
  end
endmodule : asp_uart_test
